// ===== hw/earth_fault_pkg.sv
// package: constants, carriers and types of the earth fault stage block
package earth_fault_pkg;
  localparam int STAGES = 4;
  localparam int LOG_DEPTH = 12;
  localparam int MAG_W = 16;
  localparam int TS_W = 32;
  localparam int DLY_W = 16;
  localparam int CNT_W = 16;
  localparam int EV_N = 6;
  localparam int IRQ_W = STAGES * EV_N;
  // ============================================================
  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MS_PS = 1000000000;
  localparam int MS_CYCLES = MS_PS / CLK_PERIOD_PS;
  localparam int PROG_CYCLE_MS = 5;
  localparam int PRE_TRIG_MS = 20;
  localparam int PRE_FAULT_MS = 200;
  localparam int PRE_TRIG_TAP = PRE_TRIG_MS / PROG_CYCLE_MS;
  localparam int HIST_DEPTH = PRE_FAULT_MS / PROG_CYCLE_MS;
  localparam int RESET_RATIO_PCT = 97;
  localparam int FULL_PCT = 100;
  // ============================================================
  // event bit positions and record event codes
  localparam int EV_START_ON = 0;
  localparam int EV_START_OFF = 1;
  localparam int EV_TRIP_ON = 2;
  localparam int EV_TRIP_OFF = 3;
  localparam int EV_BLOCK_ON = 4;
  localparam int EV_BLOCK_OFF = 5;
  localparam logic [1:0] REC_START = 2'h0;
  localparam logic [1:0] REC_TRIP = 2'h1;
  localparam logic [1:0] REC_BLOCK = 2'h2;
  // ============================================================
  // register map, byte addresses
  localparam logic [7:0] REG_IRQ_STAT = 8'h00;
  localparam logic [7:0] REG_IRQ_MASK = 8'h04;
  localparam logic [7:0] REG_TIME = 8'h08;
  localparam logic [7:0] REG_REC_SEL = 8'h0c;
  localparam logic [7:0] REG_REC0 = 8'h10;
  localparam logic [7:0] REG_REC1 = 8'h14;
  localparam logic [7:0] REG_REC2 = 8'h18;
  localparam logic [7:0] REG_REC3 = 8'h1c;
  localparam logic [7:0] STAGE_BASE = 8'h40;
  localparam logic [7:0] STAGE_END = 8'hc0;
  localparam int STAGE_SHIFT = 5;
  localparam logic [4:0] S_CFG = 5'h00;
  localparam logic [4:0] S_LEVEL = 5'h04;
  localparam logic [4:0] S_DELAY = 5'h08;
  localparam logic [4:0] S_STATUS = 5'h0c;
  localparam logic [4:0] S_CNT_ST = 5'h10;
  localparam logic [4:0] S_CNT_BLK = 5'h14;
  localparam logic [4:0] S_CLEAR = 5'h18;
  localparam int CFG_HARM_EN = 0;
  localparam int CFG_INVERSE_DELAY_MODE = 1;
  localparam int CFG_MASK_LSB = 2;
  localparam int HALF = 16;
  // ============================================================
  // reset values
  localparam logic [MAG_W-1:0] THR_RST = 16'h04b0;
  localparam logic [MAG_W-1:0] HARM_LIM_RST = 16'h0001;
  localparam logic [DLY_W-1:0] OP_DLY_RST = 16'h0014;
  localparam logic [DLY_W-1:0] REL_DLY_RST = 16'h0004;
  localparam logic [EV_N-1:0] MASK_RST = 6'h3f;
  // ============================================================
  // carriers
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_TRIP, ST_REL} stage_st_e;
  typedef struct packed {
    logic harm_en;
    logic inverse_delay_mode;
    logic [EV_N-1:0] ev_mask;
    logic [MAG_W-1:0] thr;
    logic [MAG_W-1:0] harm_lim;
    logic [DLY_W-1:0] op_dly;
    logic [DLY_W-1:0] rel_dly;
  } stage_cfg_s;
  typedef struct packed {
    logic [MAG_W-1:0] mag;
    logic [MAG_W-1:0] harm;
    logic [2:0] fault;
    logic [2:0] grp;
  } meas_s;
  typedef struct packed {
    logic [TS_W-1:0] ts;
    logic [1:0] ev;
    logic [2:0] fault;
    logic [2:0] grp;
    logic [DLY_W-1:0] remain;
    logic [MAG_W-1:0] pre_trig;
    logic [MAG_W-1:0] cur;
    logic [MAG_W-1:0] pre_fault;
  } record_s;
  typedef struct packed {
    logic valid;
    logic [1:0] stage;
    logic [2:0] code;
    logic [TS_W-1:0] ts;
  } event_s;
endpackage

// ===== hw/earth_fault_stage_block_events.sv
// four residual-current protection stages with events, counters, fault log and apb registers
`timescale 1ns/100ps
// Notes on behaviour
// RL1 - external block input is sampled once at each program cycle start
// RL2 - pick-up without blocking raises start and begins operate timing
// RL3 - optional second-harmonic inrush blocking, disabled by default
// RL4 - harmonic block applies when ratio reaches a limit set in 0.01 percent steps
// RL5 - pick-up while blocked raises blocked and is not processed further
// RL6 - blocking after start drops start and runs release timing
// RL7 - the blocking source must assert 5 ms before operate delay ends
// RL8 - operate timing has fixed-delay and inverse-delay modes
// RL9 - events for start, trip and block, each on and off
// RL10 - a per-event mask selects which events reach the event buffer
// RL11 - each event carries the time stamp of its transition
// RL12 - start, trip and blocked counters, clearable by command
// RL13 - four independent stages, each with its own events
// RL14 - circular log of the latest twelve records, oldest overwritten
// RL15 - records on start, trip, block on-events with currents, time, group
// RL16 - pick-up above threshold, release below 97 percent of threshold
// RL17 - blocked falls with a block-off event once no blocking is present
// RL18 - harmonic blocking is or-ed with the external block input

module ef_stage (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic tick,
  input wire logic [earth_fault_pkg::TS_W-1:0] ts,
  input wire logic blk_ext,
  input wire earth_fault_pkg::meas_s meas,
  input wire earth_fault_pkg::stage_cfg_s cfg,
  input wire logic cnt_clr,
  input wire logic [earth_fault_pkg::EV_N-1:0] ev_ack,
  input wire logic [3:0] rec_idx,
  output logic [2:0] status,
  output logic [earth_fault_pkg::EV_N-1:0] ev_now,
  output logic [earth_fault_pkg::EV_N-1:0] pend,
  output logic [earth_fault_pkg::TS_W-1:0] pend_ts,
  output logic [earth_fault_pkg::CNT_W-1:0] cnt_start,
  output logic [earth_fault_pkg::CNT_W-1:0] cnt_trip,
  output logic [earth_fault_pkg::CNT_W-1:0] cnt_blk,
  output earth_fault_pkg::record_s rec
);
  localparam int PW = $clog2(earth_fault_pkg::LOG_DEPTH);
  typedef struct packed {
    earth_fault_pkg::stage_st_e st;
    logic pick;
    logic blocked;
    logic [earth_fault_pkg::DLY_W-1:0] op_cnt;
    logic [earth_fault_pkg::DLY_W-1:0] rel_cnt;
    logic [earth_fault_pkg::EV_N-1:0] pend;
    logic [earth_fault_pkg::TS_W-1:0] pend_ts;
    logic [earth_fault_pkg::CNT_W-1:0] c_start;
    logic [earth_fault_pkg::CNT_W-1:0] c_trip;
    logic [earth_fault_pkg::CNT_W-1:0] c_blk;
    logic [PW-1:0] wptr;
    logic [earth_fault_pkg::HIST_DEPTH-1:0][earth_fault_pkg::MAG_W-1:0] hist;
    earth_fault_pkg::record_s [earth_fault_pkg::LOG_DEPTH-1:0] log;
  } stage_state_s;

  stage_state_s s_r, s_nxt;
  logic blk, harm_blk, pick_now, below_reset, was_on, is_on;
  logic [earth_fault_pkg::DLY_W-1:0] step;
  logic [earth_fault_pkg::EV_N-1:0] ev;
  earth_fault_pkg::record_s rnew;

  // ============================================================
  // decision logic, evaluated once per program cycle
  always_comb begin
    s_nxt = s_r;
    ev = '0;
    rnew = '0;
    harm_blk = cfg.harm_en && (meas.harm >= cfg.harm_lim); // see RL3 see RL4
    blk = blk_ext | harm_blk; // see RL18
    below_reset = 32'(meas.mag) * earth_fault_pkg::FULL_PCT
      < 32'(cfg.thr) * earth_fault_pkg::RESET_RATIO_PCT;
    pick_now = s_r.pick ? !below_reset : (meas.mag > cfg.thr); // see RL16
    // inverse mode runs the timer faster at higher multiples of threshold
    step = 16'h0001;
    if (cfg.inverse_delay_mode) begin // see RL8
      step = 16'h0001 + 16'({1'b0, meas.mag} >= {cfg.thr, 1'b0})
        + 16'({2'b0, meas.mag} >= {cfg.thr, 2'b0})
        + 16'({3'b0, meas.mag} >= {cfg.thr, 3'b0});
    end
    s_nxt.pend = s_r.pend & ~ev_ack;
    if (cnt_clr) begin // see RL12
      s_nxt.c_start = '0;
      s_nxt.c_trip = '0;
      s_nxt.c_blk = '0;
    end
    if (tick) begin // see RL1
      s_nxt.pick = pick_now;
      s_nxt.hist = {s_r.hist[earth_fault_pkg::HIST_DEPTH-2:0], meas.mag};
      if (blk && pick_now) begin // see RL5
        s_nxt.blocked = 1'b1;
      end else if (!blk) begin // see RL17
        s_nxt.blocked = 1'b0;
      end
      unique case (s_r.st)
        earth_fault_pkg::ST_IDLE: begin
          if (pick_now && !blk) begin // see RL2
            s_nxt.st = earth_fault_pkg::ST_RUN;
            s_nxt.op_cnt = cfg.op_dly;
          end
        end
        earth_fault_pkg::ST_RUN: begin
          if (blk || !pick_now) begin // see RL6
            s_nxt.st = earth_fault_pkg::ST_REL;
            s_nxt.rel_cnt = cfg.rel_dly;
          end else if (s_r.op_cnt <= step) begin
            s_nxt.st = earth_fault_pkg::ST_TRIP;
            s_nxt.op_cnt = '0;
          end else begin
            s_nxt.op_cnt = s_r.op_cnt - step;
          end
        end
        earth_fault_pkg::ST_TRIP: begin
          if (blk || !pick_now) begin
            s_nxt.st = earth_fault_pkg::ST_REL;
            s_nxt.rel_cnt = cfg.rel_dly;
          end
        end
        earth_fault_pkg::ST_REL: begin
          // a returning pick-up resumes the operate timer where it stopped
          if (pick_now && !blk) begin
            s_nxt.st = earth_fault_pkg::ST_RUN;
          end else if (s_r.rel_cnt == '0) begin
            s_nxt.st = earth_fault_pkg::ST_IDLE;
          end else begin
            s_nxt.rel_cnt = s_r.rel_cnt - 16'h0001;
          end
        end
      endcase
    end
    was_on = (s_r.st == earth_fault_pkg::ST_RUN) || (s_r.st == earth_fault_pkg::ST_TRIP);
    is_on = (s_nxt.st == earth_fault_pkg::ST_RUN) || (s_nxt.st == earth_fault_pkg::ST_TRIP);
    ev[earth_fault_pkg::EV_START_ON] = is_on && !was_on; // see RL9
    ev[earth_fault_pkg::EV_START_OFF] = was_on && !is_on;
    ev[earth_fault_pkg::EV_TRIP_ON] = (s_nxt.st == earth_fault_pkg::ST_TRIP)
      && (s_r.st != earth_fault_pkg::ST_TRIP);
    ev[earth_fault_pkg::EV_TRIP_OFF] = (s_r.st == earth_fault_pkg::ST_TRIP)
      && (s_nxt.st != earth_fault_pkg::ST_TRIP);
    ev[earth_fault_pkg::EV_BLOCK_ON] = s_nxt.blocked && !s_r.blocked;
    ev[earth_fault_pkg::EV_BLOCK_OFF] = s_r.blocked && !s_nxt.blocked;
    // new events win over an acknowledge in the same cycle
    if (|(ev & cfg.ev_mask)) begin // see RL10
      s_nxt.pend = s_nxt.pend | (ev & cfg.ev_mask);
      s_nxt.pend_ts = ts; // see RL11
    end
    if (ev[earth_fault_pkg::EV_START_ON]) begin
      s_nxt.c_start = s_r.c_start + 16'h0001;
    end
    if (ev[earth_fault_pkg::EV_TRIP_ON]) begin
      s_nxt.c_trip = s_r.c_trip + 16'h0001;
    end
    if (ev[earth_fault_pkg::EV_BLOCK_ON]) begin
      s_nxt.c_blk = s_r.c_blk + 16'h0001;
    end
    rnew.ts = ts; // see RL15
    rnew.ev = ev[earth_fault_pkg::EV_BLOCK_ON] ? earth_fault_pkg::REC_BLOCK
      : ev[earth_fault_pkg::EV_TRIP_ON] ? earth_fault_pkg::REC_TRIP : earth_fault_pkg::REC_START;
    rnew.fault = meas.fault;
    rnew.grp = meas.grp;
    rnew.remain = s_nxt.op_cnt;
    rnew.pre_trig = s_r.hist[earth_fault_pkg::PRE_TRIG_TAP-1];
    rnew.cur = meas.mag;
    rnew.pre_fault = s_r.hist[earth_fault_pkg::HIST_DEPTH-1];
    if (ev[earth_fault_pkg::EV_START_ON] || ev[earth_fault_pkg::EV_TRIP_ON]
        || ev[earth_fault_pkg::EV_BLOCK_ON]) begin
      s_nxt.log[s_r.wptr] = rnew; // see RL14
      s_nxt.wptr = (s_r.wptr == PW'(earth_fault_pkg::LOG_DEPTH - 1)) ? '0 : s_r.wptr + PW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign status = {s_r.blocked, s_r.st == earth_fault_pkg::ST_TRIP, was_on};
  assign ev_now = ev;
  assign pend = s_r.pend;
  assign pend_ts = s_r.pend_ts;
  assign cnt_start = s_r.c_start;
  assign cnt_trip = s_r.c_trip;
  assign cnt_blk = s_r.c_blk;
  assign rec = (rec_idx < 4'(earth_fault_pkg::LOG_DEPTH)) ? s_r.log[rec_idx] : '0;

  // ============================================================
  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  only_on_tick_a: assert property (!tick |=> $stable(s_r.st) && $stable(s_r.blocked)) // see RL1
    else $error("stage state moved outside a program cycle start");
  start_rise_a: assert property (tick && s_r.st == earth_fault_pkg::ST_IDLE && pick_now && !blk // see RL2
    |=> status[0] ##1 status[0] || tick)
    else $error("start missing after unblocked pick-up");
  harm_block_a: assert property (tick && cfg.harm_en && meas.harm >= cfg.harm_lim // see RL18
    && s_r.st == earth_fault_pkg::ST_IDLE |=> !status[0])
    else $error("start raised despite harmonic blocking");
  blocked_set_a: assert property (tick && pick_now && blk |=> status[2] && !status[1]) // see RL5
    else $error("blocked not raised on blocked pick-up");
  start_drop_a: assert property (tick && was_on && blk // see RL6
    |=> !status[0] && s_r.st == earth_fault_pkg::ST_REL && s_r.rel_cnt == cfg.rel_dly)
    else $error("start not dropped into release on blocking");
  unblock_a: assert property (tick && s_r.blocked && !blk // see RL17
    |=> !s_r.blocked && s_r.pend[earth_fault_pkg::EV_BLOCK_OFF] == cfg.ev_mask[earth_fault_pkg::EV_BLOCK_OFF])
    else $error("blocked or block-off event wrong at unblock");
  hyst_hold_a: assert property (tick && s_r.pick && !below_reset |=> s_r.pick) // see RL16
    else $error("pick-up released above reset ratio");
  count_start_a: assert property (ev[earth_fault_pkg::EV_START_ON] && !cnt_clr // see RL12
    |=> s_r.c_start == $past(s_r.c_start) + 16'h0001)
    else $error("start counter missed an occurrence");
  stamp_a: assert property (|(ev & cfg.ev_mask) |=> s_r.pend_ts == $past(ts) && |s_r.pend) // see RL11
    else $error("event time stamp or pending flag wrong");
  log_wrap_a: assert property (ev[earth_fault_pkg::EV_TRIP_ON] // see RL14
    |=> s_r.log[$past(s_r.wptr)].ev == earth_fault_pkg::REC_TRIP && s_r.wptr < PW'(earth_fault_pkg::LOG_DEPTH))
    else $error("trip record not logged");
endmodule

module earth_fault_stage_block_events #(
  parameter int MS_CYCLES = earth_fault_pkg::MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [earth_fault_pkg::STAGES-1:0] blk_pin,
  input wire earth_fault_pkg::meas_s [earth_fault_pkg::STAGES-1:0] meas,
  output earth_fault_pkg::event_s ev_out,
  output logic [earth_fault_pkg::STAGES-1:0] start_o,
  output logic [earth_fault_pkg::STAGES-1:0] trip_o,
  output logic [earth_fault_pkg::STAGES-1:0] blocked_o,
  output logic irq
);
  localparam int N = earth_fault_pkg::STAGES;
  localparam int E = earth_fault_pkg::EV_N;
  if (MS_CYCLES < 2) begin : g_chk
    $error("MS_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [31:0] ms_div;
    logic [2:0] prog_div;
    logic tick;
    logic [earth_fault_pkg::TS_W-1:0] ts;
    earth_fault_pkg::stage_cfg_s [N-1:0] cfg;
    logic [earth_fault_pkg::IRQ_W-1:0] irq_stat;
    logic [earth_fault_pkg::IRQ_W-1:0] irq_mask;
    logic [5:0] rec_sel;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    earth_fault_pkg::event_s ev_out;
    logic [N-1:0] start;
    logic [N-1:0] trip;
    logic [N-1:0] blocked;
    logic irq;
  } top_state_s;

  top_state_s s_r, s_nxt;
  logic [N-1:0][2:0] st_stat;
  logic [N-1:0][E-1:0] ev_now, pend, ack;
  logic [N-1:0][earth_fault_pkg::TS_W-1:0] pend_ts;
  logic [N-1:0][earth_fault_pkg::CNT_W-1:0] c_st, c_tr, c_bk;
  earth_fault_pkg::record_s [N-1:0] rec;
  logic [N-1:0] cnt_clr;
  logic found, wr, in_stage, bad;
  logic [1:0] sidx;
  logic [4:0] soff;
  logic [31:0] rdat;
  earth_fault_pkg::record_s rsel;

  // ============================================================
  // four independent stages
  for (genvar g = 0; g < N; g++) begin : g_stage // see RL13
    ef_stage u_stage (
      .ref_clk(ref_clk),
      .reset(reset),
      .tick(s_r.tick),
      .ts(s_r.ts),
      .blk_ext(s_r.sync2[g]),
      .meas(meas[g]),
      .cfg(s_r.cfg[g]),
      .cnt_clr(cnt_clr[g]),
      .ev_ack(ack[g]),
      .rec_idx(s_r.rec_sel[3:0]),
      .status(st_stat[g]),
      .ev_now(ev_now[g]),
      .pend(pend[g]),
      .pend_ts(pend_ts[g]),
      .cnt_start(c_st[g]),
      .cnt_trip(c_tr[g]),
      .cnt_blk(c_bk[g]),
      .rec(rec[g])
    );
  end

  always_comb begin
    s_nxt = s_r;
    ack = '0;
    found = 1'b0;
    cnt_clr = '0;
    rdat = '0;
    bad = 1'b0;
    // --- blocking pins, time base and program cycle tick
    s_nxt.sync1 = blk_pin;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.tick = 1'b0;
    s_nxt.ms_div = s_r.ms_div + 32'h1;
    if (s_r.ms_div == 32'(MS_CYCLES - 1)) begin
      s_nxt.ms_div = '0;
      s_nxt.ts = s_r.ts + 32'h1;
      s_nxt.prog_div = s_r.prog_div + 3'h1;
      if (s_r.prog_div == 3'(earth_fault_pkg::PROG_CYCLE_MS - 1)) begin
        s_nxt.prog_div = '0;
        s_nxt.tick = 1'b1;
      end
    end
    // --- one pending event per clock to the event buffer, lowest stage first
    s_nxt.ev_out = '0;
    for (int i = 0; i < N; i++) begin
      for (int j = 0; j < E; j++) begin
        if (!found && pend[i][j]) begin
          found = 1'b1;
          ack[i][j] = 1'b1;
          s_nxt.ev_out.valid = 1'b1;
          s_nxt.ev_out.stage = 2'(i);
          s_nxt.ev_out.code = 3'(j);
          s_nxt.ev_out.ts = pend_ts[i];
        end
      end
    end
    // --- apb decode
    in_stage = (paddr >= earth_fault_pkg::STAGE_BASE) && (paddr < earth_fault_pkg::STAGE_END);
    sidx = 2'((paddr - earth_fault_pkg::STAGE_BASE) >> earth_fault_pkg::STAGE_SHIFT);
    soff = paddr[4:0];
    rsel = rec[s_r.rec_sel[5:4]];
    if (in_stage) begin
      unique case (soff)
        earth_fault_pkg::S_CFG: rdat = 32'({s_r.cfg[sidx].ev_mask, s_r.cfg[sidx].inverse_delay_mode, s_r.cfg[sidx].harm_en});
        earth_fault_pkg::S_LEVEL: rdat = {s_r.cfg[sidx].harm_lim, s_r.cfg[sidx].thr};
        earth_fault_pkg::S_DELAY: rdat = {s_r.cfg[sidx].rel_dly, s_r.cfg[sidx].op_dly};
        earth_fault_pkg::S_STATUS: rdat = 32'(st_stat[sidx]);
        earth_fault_pkg::S_CNT_ST: rdat = {c_tr[sidx], c_st[sidx]};
        earth_fault_pkg::S_CNT_BLK: rdat = 32'(c_bk[sidx]);
        earth_fault_pkg::S_CLEAR: rdat = '0;
        default: bad = 1'b1;
      endcase
    end else begin
      unique case (paddr)
        earth_fault_pkg::REG_IRQ_STAT: rdat = 32'(s_r.irq_stat);
        earth_fault_pkg::REG_IRQ_MASK: rdat = 32'(s_r.irq_mask);
        earth_fault_pkg::REG_TIME: rdat = s_r.ts;
        earth_fault_pkg::REG_REC_SEL: rdat = 32'(s_r.rec_sel);
        earth_fault_pkg::REG_REC0: rdat = rsel.ts;
        earth_fault_pkg::REG_REC1: rdat = {rsel.grp, rsel.fault, 8'h00, rsel.ev, rsel.remain};
        earth_fault_pkg::REG_REC2: rdat = {rsel.pre_trig, rsel.cur};
        earth_fault_pkg::REG_REC3: rdat = {16'h0000, rsel.pre_fault};
        default: bad = 1'b1;
      endcase
    end
    // one wait state: data is captured, then pready completes the access
    s_nxt.pready = 1'b0;
    if (psel && penable && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = pwrite ? 32'h0 : rdat;
      s_nxt.pslverr = bad;
    end
    wr = psel && penable && s_r.pready && pwrite && !s_r.pslverr;
    if (wr && in_stage) begin
      unique case (soff)
        earth_fault_pkg::S_CFG: begin
          s_nxt.cfg[sidx].harm_en = pwdata[earth_fault_pkg::CFG_HARM_EN];
          s_nxt.cfg[sidx].inverse_delay_mode = pwdata[earth_fault_pkg::CFG_INVERSE_DELAY_MODE];
          s_nxt.cfg[sidx].ev_mask = pwdata[earth_fault_pkg::CFG_MASK_LSB +: E];
        end
        earth_fault_pkg::S_LEVEL: begin
          s_nxt.cfg[sidx].thr = pwdata[earth_fault_pkg::HALF-1:0];
          s_nxt.cfg[sidx].harm_lim = pwdata[31:earth_fault_pkg::HALF];
        end
        earth_fault_pkg::S_DELAY: begin
          s_nxt.cfg[sidx].op_dly = pwdata[earth_fault_pkg::HALF-1:0];
          s_nxt.cfg[sidx].rel_dly = pwdata[31:earth_fault_pkg::HALF];
        end
        earth_fault_pkg::S_CLEAR: cnt_clr[sidx] = pwdata[0]; // see RL12
        default: ;
      endcase
    end
    if (wr && !in_stage && paddr == earth_fault_pkg::REG_IRQ_MASK) begin
      s_nxt.irq_mask = pwdata[earth_fault_pkg::IRQ_W-1:0];
    end
    if (wr && !in_stage && paddr == earth_fault_pkg::REG_REC_SEL) begin
      s_nxt.rec_sel = pwdata[5:0];
    end
    // write-one-to-clear, a new event in the same cycle stays set
    if (wr && !in_stage && paddr == earth_fault_pkg::REG_IRQ_STAT) begin
      s_nxt.irq_stat = s_r.irq_stat & ~pwdata[earth_fault_pkg::IRQ_W-1:0];
    end
    s_nxt.irq_stat = s_nxt.irq_stat | ev_now;
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
    for (int i = 0; i < N; i++) begin
      s_nxt.start[i] = st_stat[i][0];
      s_nxt.trip[i] = st_stat[i][1];
      s_nxt.blocked[i] = st_stat[i][2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_r <= '0;
      for (int i = 0; i < N; i++) begin
        s_r.cfg[i].thr <= earth_fault_pkg::THR_RST;
        s_r.cfg[i].harm_lim <= earth_fault_pkg::HARM_LIM_RST;
        s_r.cfg[i].op_dly <= earth_fault_pkg::OP_DLY_RST;
        s_r.cfg[i].rel_dly <= earth_fault_pkg::REL_DLY_RST;
        s_r.cfg[i].ev_mask <= earth_fault_pkg::MASK_RST;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign ev_out = s_r.ev_out;
  assign start_o = s_r.start;
  assign trip_o = s_r.trip;
  assign blocked_o = s_r.blocked;
  assign irq = s_r.irq;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  apb_ready_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not after one wait state");
  // an unmasked event must raise irq even when software clears status in the same cycle
  irq_level_a: assert property (|(ev_now & s_r.irq_mask) |=> irq)
    else $error("irq low after an unmasked event");
endmodule

// ===== testbench/ef_far_side.sv
// far-side model: blocking matrix source and event buffer sink
`timescale 1ns/100ps
module ef_far_side (
  input wire logic ref_clk,
  input wire logic [3:0] blk_req,
  input wire earth_fault_pkg::event_s ev_out,
  output logic [3:0] blk_pin = 4'h0,
  output logic [23:0] ev_seen = 24'h000000
);
  // ============================================================
  // block source and event capture
  // block is a level held for whole program cycles, far ahead of any operate delay
  always @(posedge ref_clk) begin
    blk_pin <= blk_req;
    if (ev_out.valid) begin
      ev_seen[ev_out.stage * 6 + ev_out.code] <= 1'b1;
    end
  end
endmodule

// ===== testbench/test_earth_fault_stage_block_events.sv
// self-checking bench for the earth fault stage block
`timescale 1ns/100ps
module test_earth_fault_stage_block_events;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic er;
  logic [3:0] blk_req = 4'h2;
  logic [3:0] blk_pin;
  logic [3:0] start_o;
  logic [3:0] trip_o;
  logic [3:0] blocked_o;
  logic irq;
  logic [23:0] ev_seen;
  earth_fault_pkg::meas_s [3:0] meas = '0;
  earth_fault_pkg::event_s ev_out;
  int err_count = 0;
  int n_compared = 0;
  logic [31:0] ev_ts = 32'h00000000;
  // ============================================================
  // reset rows: address, read data, error flag
  localparam logic [40:0] ROWS [6] = '{{8'h40, 32'h000000fc, 1'b0}, {8'h44, 32'h000104b0, 1'b0},
    {8'h48, 32'h00040014, 1'b0}, {8'h50, 32'h00000000, 1'b0}, {8'h24, 32'h00000000, 1'b1},
    {8'hc0, 32'h00000000, 1'b1}};
  earth_fault_stage_block_events #(.MS_CYCLES(4)) i_dut (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .blk_pin(blk_pin), .meas(meas), .ev_out(ev_out), .start_o(start_o),
    .trip_o(trip_o), .blocked_o(blocked_o), .irq(irq));
  ef_far_side i_far (.ref_clk(ref_clk), .blk_req(blk_req), .ev_out(ev_out), .blk_pin(blk_pin),
    .ev_seen(ev_seen));
  // stamp of the stage 0 start event, which must fall on a program cycle boundary
  always @(posedge ref_clk) begin
    if (ev_out.valid && ev_out.stage == 2'h0 && ev_out.code == 3'h0) begin
      ev_ts <= ev_out.ts;
    end
  end
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk iff pready);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ============================================================
  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    foreach (ROWS[i]) begin
      apb(1'b0, ROWS[i][40:33], 32'h00000000);
      chk("reg", {er, rd}, {ROWS[i][0], ROWS[i][32:1]});
    end
    apb(1'b1, 8'h04, 32'h00ffffff);
    apb(1'b1, 8'h40, 32'h000000fe);
    apb(1'b1, 8'h80, 32'h000000fd);
    apb(1'b1, 8'ha0, 32'h00000054);
    // stage 0 runs inverse at eight times threshold and must trip well ahead of stage 3
    meas <= {{3{16'h0500, 16'h0001, 6'h00}}, 16'h2580, 16'h0000, 6'h15};
    for (int i = 0; i < 900 && trip_o[0] !== 1'b1; i++) @(negedge ref_clk);
    chk("inverse", trip_o, 4'h1);
    for (int i = 0; i < 900 && trip_o[3] !== 1'b1; i++) @(negedge ref_clk);
    chk("start", start_o, 4'h9);
    chk("trip", trip_o, 4'h9);
    chk("blocked", blocked_o, 4'h6);
    apb(1'b0, 8'h50, 32'h00000000);
    chk("count", rd, 32'h00010001);
    apb(1'b0, 8'h74, 32'h00000000);
    chk("blkcount", rd, 32'h00000001);
    apb(1'b1, 8'h58, 32'h00000001);
    apb(1'b0, 8'h50, 32'h00000000);
    chk("cleared", rd, 32'h00000000);
    apb(1'b0, 8'h00, 32'h00000000);
    chk("status", {irq, rd}, {1'b1, 32'h00150405});
    chk("events", ev_seen, 24'h150405);
    apb(1'b0, 8'h14, 32'h00000000);
    chk("record", rd, 32'ha8000014);
    apb(1'b1, 8'h0c, 32'h00000001);
    apb(1'b0, 8'h14, 32'h00000000);
    chk("record", rd, 32'ha8010000);
    apb(1'b0, 8'h18, 32'h00000000);
    chk("record", rd, 32'h25802580);
    chk("stamp", {ev_ts == 32'h0, ev_ts % earth_fault_pkg::PROG_CYCLE_MS}, 33'h0);
    apb(1'b1, 8'h00, 32'h00ffffff);
    apb(1'b0, 8'h00, 32'h00000000);
    chk("irqclr", {irq, rd}, 33'h000000000);
    blk_req <= 4'h1;
    for (int i = 0; i < 200 && start_o[1] !== 1'b1; i++) @(negedge ref_clk);
    chk("start", start_o, 4'ha);
    chk("blocked", blocked_o, 4'h5);
    @(posedge ref_clk);
    meas[3].mag <= 16'h0490;
    repeat (60) @(negedge ref_clk);
    chk("hold", start_o[3], 1'b1);
    chk("offev", {ev_seen[11:10], ev_seen[1:0]}, 4'hf);
    @(posedge ref_clk);
    meas[3].mag <= 16'h0480;
    for (int i = 0; i < 300 && start_o[3] !== 1'b0; i++) @(negedge ref_clk);
    chk("drop", start_o[3], 1'b0);
    repeat (40) @(negedge ref_clk);
    chk("masked", {ev_seen[19], ev_seen[18]}, 2'h1);
    test_done();
  end
  // hang guard: the whole sequence needs well under 2000 cycles
  initial begin
    #100000;
    err_count++;
    test_done();
  end
endmodule
